// file: inc/acr_defs.vh
`ifndef ACR_DEFS_VH
`define ACR_DEFS_VH

// ----------------------------------------------------------------
// Register sub-addresses
// ----------------------------------------------------------------
`define ACR_ADDR_COLS 8'h10
`define ACR_ADDR_MASK 8'h11
`define ACR_ADDR_VWAIT 8'h12
`define ACR_ADDR_REARM 8'h13
`define ACR_ADDR_IRQ 8'h14
`define ACR_ADDR_RATE 8'h15
`define ACR_ADDR_IDENT 8'h16
`define ACR_ADDR_VMEIRQ 8'h17
`define ACR_ADDR_BYTES 8'h18
`define ACR_ADDR_VALEN 8'h19
`define ACR_ADDR_LAUNCH 8'h1a
`define ACR_ADDR_STATUS 8'h1b

// ----------------------------------------------------------------
// Reset values and limits
// ----------------------------------------------------------------
`define ACR_COLS_MAX 8'h80
`define ACR_COLS_RST 8'h80
`define ACR_MASK_RST 4'hf
`define ACR_VWAIT_RST 8'h04
`define ACR_REARM_RST 8'h01
`define ACR_RATE_RST 2'h1
`define ACR_RATE_2GHZ 2'h1
`define ACR_RATE_1GHZ 2'h2
// Identity values are arbitrary
`define ACR_IDENT_TYPE 3'h1
`define ACR_IDENT_VER 5'h01

// ----------------------------------------------------------------
// Block read framing over the byte bus
// ----------------------------------------------------------------
`define ACR_BLK_MARK 8'hff
`define ACR_BLK_RAM_SUB 8'h0c

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define ACR_CLK_KHZ 40000
`define ACR_STEP_NS 2500
// One 2.5 us step of the 40 MHz clock
`define ACR_STEP_CYC 7'd100

`endif

// file: rtl/acr_trig_valid.v
`timescale 1ns/1ps
`default_nettype none
`include "acr_defs.vh"

module acr_trig_valid (
	input wire clk,
	input wire rst_n,
	input wire launch,
	input wire inhibit,
	input wire trig_in,
	input wire confirm_in,
	input wire val_en,
	input wire [7:0] wait_steps,
	input wire [7:0] rearm_steps,
	input wire read_done,
	output reg armed_reg,
	output reg start_reg,
	output reg [2:0] state_reg
);

localparam [2:0] ST_IDLE = 3'h0;
localparam [2:0] ST_ARMED = 3'h1;
localparam [2:0] ST_VWAIT = 3'h2;
localparam [2:0] ST_REARM = 3'h3;
localparam [2:0] ST_READ = 3'h4;
localparam [6:0] STEP_LAST = `ACR_STEP_CYC - 7'h01;

// Zero would give no window at all, so one step is the floor
function [7:0] eff_steps;
	input [7:0] s;
	begin
		eff_steps = (s == 8'h00) ? 8'h01 : s;
	end
endfunction

reg [6:0] div_reg;
reg [7:0] step_reg;
wire tick = (div_reg == STEP_LAST);

always @(posedge clk or negedge rst_n) begin
	if (!rst_n) begin
		state_reg <= ST_IDLE;
		div_reg <= 7'h00;
		step_reg <= 8'h00;
		armed_reg <= 1'b0;
		start_reg <= 1'b0;
	end else begin
		start_reg <= 1'b0;
		div_reg <= tick ? 7'h00 : div_reg + 7'h01;
		if (launch && !inhibit) begin
			state_reg <= ST_ARMED;
			armed_reg <= 1'b1;
		end else begin
			case (state_reg)
			ST_ARMED: begin
				if (trig_in) begin
					armed_reg <= 1'b0;
					div_reg <= 7'h00;
					step_reg <= 8'h00;
					if (val_en) begin
						state_reg <= ST_VWAIT;
					end else begin
						state_reg <= ST_READ;
						start_reg <= 1'b1;
					end
				end
			end
			ST_VWAIT: begin
				if (confirm_in) begin
					state_reg <= ST_READ;
					start_reg <= 1'b1;
				end else if (tick) begin
					step_reg <= step_reg + 8'h01;
					if (step_reg + 8'h01 >= eff_steps(wait_steps)) begin
						state_reg <= ST_REARM;
						step_reg <= 8'h00;
					end
				end
			end
			ST_REARM: begin
				if (tick) begin
					step_reg <= step_reg + 8'h01;
					if (step_reg + 8'h01 >= eff_steps(rearm_steps)) begin
						state_reg <= ST_ARMED;
						armed_reg <= 1'b1;
					end
				end
			end
			ST_READ: begin
				if (read_done) begin
					state_reg <= ST_IDLE;
				end
			end
			default: begin
				state_reg <= ST_IDLE;
			end
			endcase
		end
	end
end

endmodule // acr_trig_valid
`default_nettype wire

// file: rtl/acr_block_read.v
`timescale 1ns/1ps
`default_nettype none
`include "acr_defs.vh"

module acr_block_read (
	input wire clk,
	input wire rst_n,
	input wire start,
	input wire [15:0] byte_count,
	input wire addr_clr,
	input wire [15:0] ram_rdata,
	input wire byte_ready,
	output reg [15:0] raddr_reg,
	output reg byte_valid_reg,
	output reg [7:0] byte_reg,
	output reg busy_reg
);

localparam [1:0] BS_IDLE = 2'h0;
localparam [1:0] BS_WAIT = 2'h1;
localparam [1:0] BS_MSB = 2'h2;
localparam [1:0] BS_LSB = 2'h3;

reg [1:0] state_reg;
reg [15:0] left_reg;

// ----------------------------------------------------------------
// Word fetch and byte split
// ----------------------------------------------------------------
always @(posedge clk or negedge rst_n) begin
	if (!rst_n) begin
		state_reg <= BS_IDLE;
		left_reg <= 16'h0000;
		raddr_reg <= 16'h0000;
		byte_valid_reg <= 1'b0;
		byte_reg <= 8'h00;
		busy_reg <= 1'b0;
	end else begin
		case (state_reg)
		BS_IDLE: begin
			if (addr_clr) begin
				raddr_reg <= 16'h0000;
			end
			if (start && byte_count != 16'h0000) begin
				left_reg <= byte_count;
				busy_reg <= 1'b1;
				state_reg <= BS_WAIT;
			end
		end
		BS_WAIT: begin
			byte_reg <= ram_rdata[15:8];
			byte_valid_reg <= 1'b1;
			state_reg <= BS_MSB;
		end
		BS_MSB: begin
			if (byte_ready) begin
				left_reg <= left_reg - 16'h0001;
				if (left_reg == 16'h0001) begin
					byte_valid_reg <= 1'b0;
					busy_reg <= 1'b0;
					raddr_reg <= raddr_reg + 16'h0001;
					state_reg <= BS_IDLE;
				end else begin
					byte_reg <= ram_rdata[7:0];
					state_reg <= BS_LSB;
				end
			end
		end
		BS_LSB: begin
			if (byte_ready) begin
				left_reg <= left_reg - 16'h0001;
				raddr_reg <= raddr_reg + 16'h0001;
				byte_valid_reg <= 1'b0;
				if (left_reg == 16'h0001) begin
					busy_reg <= 1'b0;
					state_reg <= BS_IDLE;
				end else begin
					state_reg <= BS_WAIT;
				end
			end
		end
		default: begin
			state_reg <= BS_IDLE;
		end
		endcase
	end
end

endmodule // acr_block_read
`default_nettype wire

// file: rtl/acr_regs.v
// Overview of operation
// - Eight-bit column count limits columns read, 0..128.
// - Column count resets to 128, whole matrix.
// - Four channel enables; masked channel never written.
// - Stored frame packs only enabled channels.
// - Validation wait window counted in 2.5 us steps.
// - Wait window defaults 10 us, minimum one step.
// - No validation: wait re-arm delay, then re-arm.
// - Re-arm delay defaults and floors at one step.
// - Interrupt latched, readable, driven to the buses.
// - Write to interrupt flag clears it, unless readout completes that cycle.
// - Launch command also clears the interrupt flag.
// - Rate selector: 1 is 2 GHz, 2 is 1 GHz.
// - Read-only identity: 3-bit type, 5-bit version.
// - One gate bit passes interrupt to VME line.
// - Sixteen-bit byte count for byte-bus block reads.
// - Block read gives word high byte, then low.
// - Validation on: readout waits for confirm input.
`timescale 1ns/1ps
`default_nettype none
`include "acr_defs.vh"

module acr_regs #(
	parameter [2:0] IDENT_TYPE = `ACR_IDENT_TYPE,
	parameter [4:0] IDENT_VER = `ACR_IDENT_VER
) (
	input wire clk,
	input wire rst_n,
	input wire [7:0] bus_addr,
	input wire bus_wr,
	input wire bus_rd,
	input wire [15:0] bus_wdata,
	output reg [15:0] bus_rdata,
	input wire cmd_byte_valid,
	input wire [7:0] cmd_byte,
	input wire trig_in,
	input wire trigger_confirm_input,
	input wire [47:0] adc_data,
	input wire [15:0] ram_rdata,
	input wire gpib_byte_ready,
	output reg ram_we,
	output reg [15:0] ram_waddr,
	output reg [11:0] ram_wdata,
	output wire [15:0] ram_raddr,
	output wire gpib_byte_valid,
	output wire [7:0] gpib_byte,
	output reg acq_irq,
	output reg vme_irq3,
	output reg [1:0] sample_rate,
	output wire trig_armed
);

// ----------------------------------------------------------------
// Identity byte (type and version values are arbitrary)
// ----------------------------------------------------------------
wire [7:0] firmware_identity = {IDENT_TYPE, IDENT_VER};

// ----------------------------------------------------------------
// Register storage
// ----------------------------------------------------------------
reg [7:0] column_read_count;
reg [3:0] channel_enable_mask;
reg [7:0] validation_wait_window;
reg [7:0] trigger_rearm_delay;
reg irq_flag;
reg [1:0] sample_rate_select;
reg vme_irq_gate;
reg [15:0] gpib_block_byte_count;
reg trigger_validation_enable;

// The launch command is a write to its own sub-address
wire wr_hit_irq = bus_wr && (bus_addr == `ACR_ADDR_IRQ);
wire acquisition_launch_command = bus_wr &&
	(bus_addr == `ACR_ADDR_LAUNCH);

// Column counts above the matrix size are held at the maximum
function [7:0] clamp_cols;
	input [7:0] v;
	begin
		clamp_cols = (v > `ACR_COLS_MAX) ? `ACR_COLS_MAX : v;
	end
endfunction

wire seq_done;
wire [2:0] trig_state;
wire blk_busy;
reg blk_start;
reg [15:0] blk_count;

// ----------------------------------------------------------------
// Register writes
// ----------------------------------------------------------------
always @(posedge clk or negedge rst_n) begin
	if (!rst_n) begin
		column_read_count <= `ACR_COLS_RST;
		channel_enable_mask <= `ACR_MASK_RST;
		validation_wait_window <= `ACR_VWAIT_RST;
		trigger_rearm_delay <= `ACR_REARM_RST;
		sample_rate_select <= `ACR_RATE_RST;
		vme_irq_gate <= 1'b0;
		gpib_block_byte_count <= 16'h0000;
		trigger_validation_enable <= 1'b0;
	end else begin
		if (bus_wr) begin
			case (bus_addr)
			`ACR_ADDR_COLS: begin
				column_read_count <= clamp_cols(bus_wdata[7:0]);
			end
			`ACR_ADDR_MASK: begin
				channel_enable_mask <= bus_wdata[3:0];
			end
			`ACR_ADDR_VWAIT: begin
				validation_wait_window <= bus_wdata[7:0];
			end
			`ACR_ADDR_REARM: begin
				trigger_rearm_delay <= bus_wdata[7:0];
			end
			`ACR_ADDR_RATE: begin
				sample_rate_select <= bus_wdata[1:0];
			end
			`ACR_ADDR_VMEIRQ: begin
				vme_irq_gate <= bus_wdata[0];
			end
			`ACR_ADDR_BYTES: begin
				gpib_block_byte_count <= bus_wdata;
			end
			`ACR_ADDR_VALEN: begin
				trigger_validation_enable <= bus_wdata[0];
			end
			default: begin
			end
			endcase
		end
		// A block read command also loads the byte count
		if (blk_start) begin
			gpib_block_byte_count <= blk_count;
		end
	end
end

// ----------------------------------------------------------------
// Interrupt flag: completion wins over a clear in the same cycle
// ----------------------------------------------------------------
always @(posedge clk or negedge rst_n) begin
	if (!rst_n) begin
		irq_flag <= 1'b0;
		acq_irq <= 1'b0;
		vme_irq3 <= 1'b0;
	end else begin
		if (seq_done) begin
			irq_flag <= 1'b1;
		end else if (wr_hit_irq) begin
			irq_flag <= 1'b0;
		end else if (acquisition_launch_command) begin
			irq_flag <= 1'b0;
		end
		acq_irq <= irq_flag;
		vme_irq3 <= irq_flag && vme_irq_gate;
	end
end

// ----------------------------------------------------------------
// Sample rate output
// ----------------------------------------------------------------
always @(posedge clk or negedge rst_n) begin
	if (!rst_n) begin
		sample_rate <= `ACR_RATE_RST;
	end else begin
		sample_rate <= sample_rate_select;
	end
end

// ----------------------------------------------------------------
// Read data
// ----------------------------------------------------------------
always @(posedge clk or negedge rst_n) begin
	if (!rst_n) begin
		bus_rdata <= 16'h0000;
	end else if (bus_rd) begin
		case (bus_addr)
		`ACR_ADDR_COLS: bus_rdata <= {8'h00, column_read_count};
		`ACR_ADDR_MASK: bus_rdata <= {12'h000, channel_enable_mask};
		`ACR_ADDR_VWAIT: bus_rdata <= {8'h00, validation_wait_window};
		`ACR_ADDR_REARM: bus_rdata <= {8'h00, trigger_rearm_delay};
		`ACR_ADDR_IRQ: bus_rdata <= {15'h0000, irq_flag};
		`ACR_ADDR_RATE: bus_rdata <= {14'h0000, sample_rate_select};
		`ACR_ADDR_IDENT: bus_rdata <= {8'h00, firmware_identity};
		`ACR_ADDR_VMEIRQ: bus_rdata <= {15'h0000, vme_irq_gate};
		`ACR_ADDR_BYTES: bus_rdata <= gpib_block_byte_count;
		`ACR_ADDR_VALEN: bus_rdata <= {15'h0000, trigger_validation_enable};
		`ACR_ADDR_STATUS: bus_rdata <= {10'h000, blk_busy, trig_armed,
			1'b0, trig_state};
		default: bus_rdata <= 16'h0000;
		endcase
	end
end

// ----------------------------------------------------------------
// Trigger validation and re-arm timing
// ----------------------------------------------------------------
wire seq_start;

acr_trig_valid u_trig (
	.clk(clk),
	.rst_n(rst_n),
	.launch(acquisition_launch_command),
	.inhibit(1'b0),
	.trig_in(trig_in),
	.confirm_in(trigger_confirm_input),
	.val_en(trigger_validation_enable),
	.wait_steps(validation_wait_window),
	.rearm_steps(trigger_rearm_delay),
	.read_done(seq_done),
	.armed_reg(trig_armed),
	.start_reg(seq_start),
	.state_reg(trig_state)
);

// ----------------------------------------------------------------
// Matrix readout into RAM, enabled channels packed per column
// ----------------------------------------------------------------
reg seq_busy;
reg [7:0] col_reg;
reg [1:0] ch_reg;
reg done_reg;
assign seq_done = done_reg;

always @(posedge clk or negedge rst_n) begin
	if (!rst_n) begin
		seq_busy <= 1'b0;
		col_reg <= 8'h00;
		ch_reg <= 2'h0;
		done_reg <= 1'b0;
		ram_we <= 1'b0;
		ram_wdata <= 12'h000;
	end else begin
		done_reg <= 1'b0;
		ram_we <= 1'b0;
		if (seq_start) begin
			col_reg <= 8'h00;
			ch_reg <= 2'h0;
			// Column count of zero ends the readout at once
			if (column_read_count == 8'h00) begin
				done_reg <= 1'b1;
			end else begin
				seq_busy <= 1'b1;
			end
		end else if (seq_busy) begin
			if (channel_enable_mask[ch_reg]) begin
				ram_we <= 1'b1;
				ram_wdata <= adc_data[ch_reg * 12 +: 12];
			end
			ch_reg <= ch_reg + 2'h1;
			if (ch_reg == 2'h3) begin
				col_reg <= col_reg + 8'h01;
				if (col_reg + 8'h01 >= column_read_count) begin
					seq_busy <= 1'b0;
					done_reg <= 1'b1;
				end
			end
		end
	end
end

// ----------------------------------------------------------------
// Packed write address: steps once after every stored sample, so
// masked channels leave no holes in the frame
// ----------------------------------------------------------------
always @(posedge clk or negedge rst_n) begin
	if (!rst_n) begin
		ram_waddr <= 16'h0000;
	end else if (seq_start) begin
		ram_waddr <= 16'h0000;
	end else if (ram_we) begin
		ram_waddr <= ram_waddr + 16'h0001;
	end
end

// ----------------------------------------------------------------
// Block read framing from the byte command stream
// ----------------------------------------------------------------
localparam [1:0] FR_MARK = 2'h0;
localparam [1:0] FR_LOW = 2'h1;
localparam [1:0] FR_HIGH = 2'h2;
localparam [1:0] FR_SUB = 2'h3;
reg [1:0] fr_state;

always @(posedge clk or negedge rst_n) begin
	if (!rst_n) begin
		fr_state <= FR_MARK;
		blk_count <= 16'h0000;
		blk_start <= 1'b0;
	end else begin
		blk_start <= 1'b0;
		if (cmd_byte_valid) begin
			case (fr_state)
			FR_MARK: begin
				if (cmd_byte == `ACR_BLK_MARK) begin
					fr_state <= FR_LOW;
				end
			end
			FR_LOW: begin
				blk_count[7:0] <= cmd_byte;
				fr_state <= FR_HIGH;
			end
			FR_HIGH: begin
				blk_count[15:8] <= cmd_byte;
				fr_state <= FR_SUB;
			end
			FR_SUB: begin
				// Any other fourth byte drops the frame
				if (cmd_byte == `ACR_BLK_RAM_SUB && !blk_busy) begin
					blk_start <= 1'b1;
				end
				fr_state <= FR_MARK;
			end
			default: begin
				fr_state <= FR_MARK;
			end
			endcase
		end
	end
end

acr_block_read u_blk (
	.clk(clk),
	.rst_n(rst_n),
	.start(blk_start),
	// Framed count, not the register: both move on the same edge
	.byte_count(blk_count),
	.addr_clr(seq_done),
	.ram_rdata(ram_rdata),
	.byte_ready(gpib_byte_ready),
	.raddr_reg(ram_raddr),
	.byte_valid_reg(gpib_byte_valid),
	.byte_reg(gpib_byte),
	.busy_reg(blk_busy)
);

endmodule // acr_regs
`default_nettype wire

// file: verif/acr_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// Byte-bus host: sends block read command, sinks bytes
// ----------------------------------------------------------------
module acr_host_model (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic go,
	input wire logic [15:0] count,
	input wire logic stall,
	output logic cmd_byte_valid,
	output logic [7:0] cmd_byte,
	output logic gpib_byte_ready
);
	logic [2:0] step_reg;
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			step_reg <= 3'h0;
			cmd_byte_valid <= 1'b0;
			cmd_byte <= 8'h00;
			gpib_byte_ready <= 1'b0;
		end else begin
			gpib_byte_ready <= !stall;
			cmd_byte_valid <= 1'b0;
			// Released byte lane shows junk
			cmd_byte <= ~cmd_byte;
			if (go && step_reg == 3'h0) begin
				step_reg <= 3'h1;
			end else if (step_reg != 3'h0 && !cmd_byte_valid) begin
				cmd_byte_valid <= 1'b1;
				step_reg <= (step_reg == 3'h4) ? 3'h0 : step_reg + 3'h1;
				case (step_reg)
					3'h1: cmd_byte <= 8'hff;
					3'h2: cmd_byte <= count[7:0];
					3'h3: cmd_byte <= count[15:8];
					default: cmd_byte <= 8'h0c;
				endcase
			end
		end
	end
endmodule // acr_host_model
`default_nettype wire

// file: verif/acr_regs_sva.sv
`timescale 1ns/1ps
`default_nettype none
module acr_regs_chk #(
	parameter [2:0] IDENT_TYPE = 3'h1,
	parameter [4:0] IDENT_VER = 5'h01
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [7:0] bus_addr,
	input wire logic bus_wr,
	input wire logic bus_rd,
	input wire logic [15:0] bus_wdata,
	input wire logic [15:0] bus_rdata,
	input wire logic gpib_byte_ready,
	input wire logic gpib_byte_valid,
	input wire logic [7:0] gpib_byte,
	input wire logic acq_irq,
	input wire logic vme_irq3,
	input wire logic [1:0] sample_rate,
	input wire logic trig_armed,
	input wire logic ram_we,
	input wire logic [15:0] ram_waddr
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	AST_RATE: assert property (bus_wr && bus_addr == 8'h15 &&
		bus_wdata[1:0] == 2'h2 |-> ##[1:2] sample_rate == 2'h2)
		else $error("rate select not applied");
	AST_IRQ_CLR: assert property (bus_wr && bus_addr == 8'h14
		|-> ##2 !acq_irq) else $error("irq write did not clear");
	AST_LAUNCH_CLR: assert property (bus_wr && bus_addr == 8'h1a
		|-> ##2 !acq_irq) else $error("launch did not clear irq");
	AST_VME_GATE: assert property (vme_irq3 |-> acq_irq)
		else $error("vme irq without flag");
	AST_ARM: assert property (bus_wr && bus_addr == 8'h1a
		|=> trig_armed) else $error("launch did not arm");
	AST_IDENT: assert property (bus_rd && bus_addr == 8'h16
		|=> bus_rdata == {8'h00, IDENT_TYPE, IDENT_VER})
		else $error("identity mismatch");
	AST_RDATA_HOLD: assert property (!bus_rd |=> $stable(bus_rdata))
		else $error("read data moved");
	AST_BYTE_HOLD: assert property (gpib_byte_valid && !gpib_byte_ready
		|=> gpib_byte_valid && $stable(gpib_byte))
		else $error("byte dropped before accept");
	AST_WADDR: assert property (ram_we && $past(ram_we)
		|-> ram_waddr == $past(ram_waddr) + 16'h1)
		else $error("write address not packed");
endmodule // acr_regs_chk
bind acr_regs acr_regs_chk #(.IDENT_TYPE(IDENT_TYPE), .IDENT_VER(IDENT_VER))
	u_chk (.clk(clk), .rst_n(rst_n), .bus_addr(bus_addr), .bus_wr(bus_wr),
	.bus_rd(bus_rd), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
	.gpib_byte_ready(gpib_byte_ready), .gpib_byte_valid(gpib_byte_valid),
	.gpib_byte(gpib_byte), .acq_irq(acq_irq), .vme_irq3(vme_irq3),
	.sample_rate(sample_rate), .trig_armed(trig_armed), .ram_we(ram_we),
	.ram_waddr(ram_waddr));
`default_nettype wire

// file: verif/acq_control_register_set_bench.sv
`timescale 1ns/1ps
`default_nettype none
module acq_control_register_set_bench;
	logic clk, rst_n, bus_wr, bus_rd, cmd_byte_valid, trig_in, ram_we;
	logic trigger_confirm_input, gpib_byte_ready, gpib_byte_valid, stall;
	logic acq_irq, vme_irq3, trig_armed, host_go;
	logic [7:0] bus_addr, cmd_byte, gpib_byte;
	logic [15:0] bus_wdata, bus_rdata, ram_waddr, ram_raddr, ram_rdata;
	logic [11:0] ram_wdata;
	logic [1:0] sample_rate;
	logic [47:0] adc_data;
	logic [7:0] rx[$];
	int error_cnt, samples_checked, i, n;
	assign ram_rdata = ram_raddr ^ 16'h5a3c;
	// Identity values are arbitrary
	acr_regs #(.IDENT_TYPE(3'h5), .IDENT_VER(5'h0a)) uut (.clk(clk),
		.rst_n(rst_n), .bus_addr(bus_addr), .bus_wr(bus_wr), .bus_rd(bus_rd),
		.bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
		.cmd_byte_valid(cmd_byte_valid), .cmd_byte(cmd_byte),
		.trig_in(trig_in), .trigger_confirm_input(trigger_confirm_input),
		.adc_data(adc_data), .ram_rdata(ram_rdata),
		.gpib_byte_ready(gpib_byte_ready), .ram_we(ram_we),
		.ram_waddr(ram_waddr), .ram_wdata(ram_wdata), .ram_raddr(ram_raddr),
		.gpib_byte_valid(gpib_byte_valid), .gpib_byte(gpib_byte),
		.acq_irq(acq_irq), .vme_irq3(vme_irq3), .sample_rate(sample_rate),
		.trig_armed(trig_armed));
	acr_host_model host (.clk(clk), .rst_n(rst_n), .go(host_go),
		.count(16'h0006), .stall(stall), .cmd_byte_valid(cmd_byte_valid),
		.cmd_byte(cmd_byte), .gpib_byte_ready(gpib_byte_ready));
	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	task automatic step;
		@(posedge clk);
		#1;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("[FAIL] %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		step;
		bus_addr = a;
		bus_wdata = d;
		bus_wr = 1'b1;
		step;
		bus_wr = 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [15:0] exp);
		step;
		bus_addr = a;
		bus_rd = 1'b1;
		step;
		bus_rd = 1'b0;
		chk(bus_rdata, exp);
	endtask
	task automatic trig;
		step;
		trig_in = 1'b1;
		step;
		trig_in = 1'b0;
	endtask
	task automatic wait_irq;
		for (i = 0; i < 400 && acq_irq !== 1'b1; i++) step;
	endtask
	task automatic tally_and_finish;
		$display("checked %0d, errors %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_defaults;
		rd(8'h10, 16'h0080);
		rd(8'h11, 16'h000f);
		rd(8'h12, 16'h0004);
		rd(8'h13, 16'h0001);
		rd(8'h15, 16'h0001);
		chk({14'h0, sample_rate}, 16'h0001);
		rd(8'h16, 16'h00aa);
		$display("t_defaults done");
	endtask
	task automatic t_access;
		wr(8'h10, 16'h0085);
		rd(8'h10, 16'h0080);
		wr(8'h10, 16'h007f);
		rd(8'h10, 16'h007f);
		wr(8'h16, 16'h0000);
		rd(8'h16, 16'h00aa);
		rd(8'h3f, 16'h0000);
		wr(8'h18, 16'hbeef);
		rd(8'h18, 16'hbeef);
		wr(8'h15, 16'h0002);
		step;
		chk({14'h0, sample_rate}, 16'h0002);
		wr(8'h15, 16'h0001);
		step;
		chk({14'h0, sample_rate}, 16'h0001);
		$display("t_access done");
	endtask
	task automatic t_acq;
		wr(8'h10, 16'h0002);
		wr(8'h11, 16'h0005);
		wr(8'h19, 16'h0000);
		wr(8'h17, 16'h0001);
		wr(8'h1a, 16'h0000);
		trig;
		n = 0;
		for (i = 0; i < 400 && acq_irq !== 1'b1; i++) begin
			step;
			if (ram_we === 1'b1) begin
				chk(ram_waddr, n[15:0]);
				chk({4'h0, ram_wdata}, n[0] ? 16'h02b2 : 16'h0090);
				n++;
			end
		end
		chk(n[15:0], 16'h0004);
		step;
		chk({15'h0, vme_irq3}, 16'h0001);
		rd(8'h14, 16'h0001);
		wr(8'h14, 16'h1234);
		step;
		chk({14'h0, acq_irq, vme_irq3}, 16'h0000);
		rd(8'h14, 16'h0000);
		wr(8'h17, 16'h0000);
		wr(8'h10, 16'h0000);
		wr(8'h1a, 16'h0000);
		trig;
		wait_irq;
		step;
		chk({14'h0, acq_irq, vme_irq3}, 16'h0002);
		wr(8'h1a, 16'h0000);
		step;
		chk({15'h0, acq_irq}, 16'h0000);
		$display("t_acq done");
	endtask
	task automatic t_valid;
		wr(8'h10, 16'h0001);
		wr(8'h11, 16'h0003);
		wr(8'h12, 16'h0001);
		wr(8'h13, 16'h0001);
		wr(8'h19, 16'h0001);
		wr(8'h1a, 16'h0000);
		trig;
		n = 0;
		for (i = 0; i < 400 && trig_armed !== 1'b1; i++) begin
			step;
			if (ram_we === 1'b1) n++;
		end
		chk(n[15:0], 16'h0000);
		chk({15'h0, i >= 197 && i <= 203}, 16'h0001);
		chk({15'h0, trig_armed}, 16'h0001);
		trigger_confirm_input = 1'b1;
		trig;
		for (i = 0; i < 50 && ram_we !== 1'b1; i++) step;
		chk({15'h0, ram_we}, 16'h0001);
		wait_irq;
		trigger_confirm_input = 1'b0;
		wr(8'h14, 16'h0000);
		$display("t_valid done");
	endtask
	task automatic t_block;
		rx.delete();
		step;
		host_go = 1'b1;
		step;
		host_go = 1'b0;
		for (i = 0; i < 300 && rx.size() < 6; i++) step;
		repeat (20) step;
		chk(rx.size(), 16'h0006);
		rd(8'h18, 16'h0006);
		chk(ram_raddr, 16'h0003);
		for (n = 0; n < 6 && n < rx.size(); n++)
			chk({8'h0, rx[n]}, n[0] ? {8'h0, n[8:1] ^ 8'h3c} : 16'h005a);
		$display("t_block done");
	endtask
	// ----------------------------------------------------------------
	// Clock, stimulus, capture, watchdog
	// ----------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	initial begin
		forever begin
			step;
			stall = ~stall;
		end
	end
	always @(posedge clk)
		if (gpib_byte_valid === 1'b1 && gpib_byte_ready === 1'b1)
			rx.push_back(gpib_byte);
	initial begin
		#(25 * 20000);
		error_cnt++;
		tally_and_finish;
	end
	initial begin
		rst_n = 1'b0;
		{bus_wr, bus_rd, trig_in, trigger_confirm_input, host_go} = 5'h00;
		stall = 1'b0;
		bus_addr = 8'h00;
		bus_wdata = 16'h0000;
		adc_data = {12'h3c3, 12'h2b2, 12'h1a1, 12'h090};
		error_cnt = 0;
		samples_checked = 0;
		repeat (5) @(posedge clk);
		#1;
		rst_n = 1'b1;
		t_defaults;
		t_access;
		t_acq;
		t_valid;
		t_block;
		tally_and_finish;
	end
endmodule // acq_control_register_set_bench
`default_nettype wire
